// File: common/ltr_pkg.sv
// package: offsets, fields, reset values and types of the link tuning regs
package ltr_pkg;

  // ==========================================================================
  // register map (byte addresses)
  localparam logic [7:0] ADDR_ID_STD   = 8'h2C;
  localparam logic [7:0] ADDR_TUNING   = 8'hF4;
  localparam logic [7:0] ADDR_ID_ALIAS = 8'hF8;

  // ==========================================================================
  // tuning register fields
  localparam int THR_LSB      = 12;
  localparam int MUSIC_BIT    = 9;
  localparam int VIDEO_BIT    = 8;
  localparam int PRIO_BIT     = 7;
  localparam int IDLE_BIT     = 2;
  localparam int SPEED_BIT    = 1;
  localparam logic [31:0] TUNING_RW_MASK = 32'h0000_3386;
  localparam logic [31:0] TUNING_RESET   = 32'h0000_1000;
  localparam logic [31:0] ID_RESET       = 32'h0000_0000;

  // ==========================================================================
  // threshold codes and stream format codes
  localparam logic [1:0] THR_2K    = 2'h0;
  localparam logic [1:0] THR_1K7   = 2'h1;
  localparam logic [1:0] THR_1K    = 2'h2;
  localparam logic [1:0] THR_512   = 2'h3;
  localparam logic [7:0] FMT_MUSIC = 8'h10;
  localparam logic [7:0] FMT_VIDEO = 8'h00;

  // ==========================================================================
  // effective controls handed to the link datapath
  typedef struct packed {
    logic [1:0] tx_fifo_threshold_sel;
    logic       music_stamp_fix;
    logic       video_stamp_fix;
    logic       priority_request;
    logic       idle_insertion;
    logic       speedup_features;
  } ltr_ctl_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [31:0] data;
  } ltr_load_s;

endpackage : ltr_pkg

// File: design/ltr_regs.sv
// link tuning control and subsystem identity registers
`timescale 1ns/1ps
// Summary of operation
// - reserved tuning bits 31-14, 11-10, 6, 5-3 and 0 read as zero.
// - bits 13-12 pick the initial transmit FIFO threshold until underrun.
// - threshold codes 00 2K, 01 1.7K reset, 10 1K, 11 512 bytes.
// - a retried packet after underrun uses the 2K store-and-forward threshold.
// - bit 9 enables music stamp fix for streams with format 10h.
// - bit 8 enables video stamp fix for streams with format 00h.
// - bit 7 enables asynchronous priority arbitration requests.
// - bit 2 enables idle insertion in the transmit logic.
// - bit 1 enables the link speedup features.
// - bit 6 stays reserved and read-only.
// - identity register at F8h is aliased at 2Ch, reading back the same.
// - identity bits 31-16 device code, 15-0 vendor code, both writable.
// - tuning enables act only while the phy tuning master enable is set.
// - registers load from software writes or a serial ROM load port.
module ltr_regs (
  input  wire logic                i_mclk,
  input  wire logic                i_nrst,
  input  wire logic [7:0]          i_addr,
  input  wire logic [31:0]         i_wdata,
  input  wire logic                i_wr,
  input  wire logic                i_rd,
  input  wire ltr_pkg::ltr_load_s  i_load,
  input  wire logic                i_phy_tuning_master_en,
  input  wire logic                i_tx_retry,
  input  wire logic [7:0]          i_tx_fmt,
  output logic [31:0]              o_rdata,
  output ltr_pkg::ltr_ctl_s        o_ctl,
  output logic                     o_music_fix_now,
  output logic                     o_video_fix_now,
  output logic                     o_tx_threshold_eff_2k
);

  // ==========================================================================
  // pin synchronisers: master enable comes from another register block
  logic phy_en_s1;
  logic phy_en;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      phy_en_s1 <= 1'b0;
      phy_en    <= 1'b0;
    end else begin
      phy_en_s1 <= i_phy_tuning_master_en;
      phy_en    <= phy_en_s1;
    end
  end

  // ==========================================================================
  // storage
  logic [31:0] tuning;
  logic [31:0] ident;
  logic        wr_tuning;
  logic        wr_ident;
  logic [31:0] wsrc;

  // rom load shares the write path; software wins if both arrive at once
  always_comb begin
    wsrc      = i_wdata;
    wr_tuning = 1'b0;
    wr_ident  = 1'b0;
    if (i_wr) begin
      wr_tuning = (i_addr == ltr_pkg::ADDR_TUNING);
      wr_ident  = (i_addr == ltr_pkg::ADDR_ID_ALIAS) ||
                  (i_addr == ltr_pkg::ADDR_ID_STD);
    end else if (i_load.valid) begin
      wsrc      = i_load.data;
      wr_tuning = (i_load.addr == ltr_pkg::ADDR_TUNING);
      wr_ident  = (i_load.addr == ltr_pkg::ADDR_ID_ALIAS);
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      tuning <= ltr_pkg::TUNING_RESET;
    end else if (wr_tuning) begin
      // only writable bits stored; reserved stay zero
      tuning <= wsrc & ltr_pkg::TUNING_RW_MASK;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ident <= ltr_pkg::ID_RESET;
    end else if (wr_ident) begin
      ident <= wsrc;
    end
  end

  // ==========================================================================
  // read port: data the cycle after the strobe, zero elsewhere
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      case (i_addr)
        ltr_pkg::ADDR_TUNING:   o_rdata <= tuning;
        ltr_pkg::ADDR_ID_ALIAS: o_rdata <= ident;
        ltr_pkg::ADDR_ID_STD:   o_rdata <= ident;
        default:                o_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

  // ==========================================================================
  // effective controls
  // retry is a level from the transmit side; no latch, so the forced
  // store-and-forward threshold drops the cycle after the retry ends
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ctl <= '0;
    end else begin
      o_ctl.tx_fifo_threshold_sel <= i_tx_retry ? ltr_pkg::THR_2K :
        tuning[ltr_pkg::THR_LSB +: 2];
      o_ctl.music_stamp_fix  <= phy_en & tuning[ltr_pkg::MUSIC_BIT];
      o_ctl.video_stamp_fix  <= phy_en & tuning[ltr_pkg::VIDEO_BIT];
      o_ctl.priority_request <= phy_en & tuning[ltr_pkg::PRIO_BIT];
      o_ctl.idle_insertion   <= phy_en & tuning[ltr_pkg::IDLE_BIT];
      o_ctl.speedup_features <= phy_en & tuning[ltr_pkg::SPEED_BIT];
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_music_fix_now       <= 1'b0;
      o_video_fix_now       <= 1'b0;
      o_tx_threshold_eff_2k <= 1'b0;
    end else begin
      o_music_fix_now <= phy_en & tuning[ltr_pkg::MUSIC_BIT] &
                         (i_tx_fmt == ltr_pkg::FMT_MUSIC);
      o_video_fix_now <= phy_en & tuning[ltr_pkg::VIDEO_BIT] &
                         (i_tx_fmt == ltr_pkg::FMT_VIDEO);
      o_tx_threshold_eff_2k <= i_tx_retry |
        (tuning[ltr_pkg::THR_LSB +: 2] == ltr_pkg::THR_2K);
    end
  end

  // ==========================================================================
  // checks
  sequence s_rd_tuning;
    i_rd && !i_wr && i_addr == ltr_pkg::ADDR_TUNING;
  endsequence

  sequence s_wr_alias;
    i_wr && i_addr == ltr_pkg::ADDR_ID_ALIAS;
  endsequence

  sequence s_rd_std;
    i_rd && !i_wr && i_addr == ltr_pkg::ADDR_ID_STD;
  endsequence

  // no write source at all: stored values must hold
  sequence s_sw_quiet;
    !i_wr && !i_load.valid;
  endsequence

  sequence s_load_tuning;
    !i_wr && i_load.valid && i_load.addr == ltr_pkg::ADDR_TUNING;
  endsequence

  sequence s_load_ident;
    !i_wr && i_load.valid && i_load.addr == ltr_pkg::ADDR_ID_ALIAS;
  endsequence

  // rom may not reach the standard identity slot directly
  sequence s_load_std;
    !i_wr && i_load.valid && i_load.addr == ltr_pkg::ADDR_ID_STD;
  endsequence

  AST_RSVD_ZERO: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    s_rd_tuning |=> (o_rdata & ~ltr_pkg::TUNING_RW_MASK) == 32'h0)
    else $error("reserved tuning bits read nonzero");

  AST_BIT6_ZERO: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    tuning[6] == 1'b0)
    else $error("bit 6 stored");

  AST_THR_WRITE: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    i_wr && i_addr == ltr_pkg::ADDR_TUNING |=>
      tuning[13:12] == $past(i_wdata[13:12]))
    else $error("threshold not written");

  AST_RETRY_2K: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    i_tx_retry |=> o_ctl.tx_fifo_threshold_sel == ltr_pkg::THR_2K
      && o_tx_threshold_eff_2k)
    else $error("retry not store and forward");

  AST_MUSIC: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    o_music_fix_now |-> $past(i_tx_fmt) == ltr_pkg::FMT_MUSIC)
    else $error("music fix on wrong format");

  AST_VIDEO: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    o_video_fix_now |-> $past(i_tx_fmt) == ltr_pkg::FMT_VIDEO)
    else $error("video fix on wrong format");

  AST_MASTER_GATE: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    !phy_en |=> !o_ctl.priority_request && !o_ctl.idle_insertion
      && !o_ctl.speedup_features)
    else $error("enables active without master enable");

  AST_ALIAS: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    s_wr_alias ##1 s_rd_std |=> o_rdata == $past(i_wdata, 2))
    else $error("alias readback mismatch");

  AST_RSVD_WR: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (tuning & ~ltr_pkg::TUNING_RW_MASK) == 32'h0)
    else $error("reserved bit stored");

  // ==========================================================================
  // read port checks
  AST_RD_IDLE_ZERO: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    !i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data outside read cycle");

  AST_RD_UNMAPPED: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    i_rd && i_addr != ltr_pkg::ADDR_TUNING &&
      i_addr != ltr_pkg::ADDR_ID_ALIAS && i_addr != ltr_pkg::ADDR_ID_STD
      |=> o_rdata == 32'h0000_0000)
    else $error("unmapped read nonzero");

  AST_RD_TUNING_EQ: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    s_rd_tuning |=> o_rdata == $past(tuning))
    else $error("tuning readback wrong");

  AST_RD_STD_EQ: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    s_rd_std |=> o_rdata == $past(ident))
    else $error("standard identity readback wrong");

  AST_RD_ALIAS_EQ: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    i_rd && !i_wr && i_addr == ltr_pkg::ADDR_ID_ALIAS
      |=> o_rdata == $past(ident))
    else $error("alias identity readback wrong");

  // ==========================================================================
  // storage checks
  AST_ID_WRITE: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    s_wr_alias |=> ident == $past(i_wdata))
    else $error("identity write lost");

  AST_ID_WRITE_STD: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    i_wr && i_addr == ltr_pkg::ADDR_ID_STD |=> ident == $past(i_wdata))
    else $error("standard slot write lost");

  AST_LOAD_TUNING: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    s_load_tuning |=>
      tuning == ($past(i_load.data) & ltr_pkg::TUNING_RW_MASK))
    else $error("rom load of tuning lost");

  AST_LOAD_IDENT: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    s_load_ident |=> ident == $past(i_load.data))
    else $error("rom load of identity lost");

  AST_LOAD_STD_IGN: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    s_load_std |=> $stable(ident) && $stable(tuning))
    else $error("rom load hit standard slot");

  // software write wins; the rom word in that cycle is dropped
  AST_WR_BEATS_LOAD: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    i_wr && i_addr == ltr_pkg::ADDR_TUNING && i_load.valid
      |=> tuning == ($past(i_wdata) & ltr_pkg::TUNING_RW_MASK))
    else $error("rom load beat software write");

  AST_HOLD: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    s_sw_quiet |=> $stable(tuning) && $stable(ident))
    else $error("stored value moved without a write");

  // ==========================================================================
  // effective control checks
  AST_THR_FREE: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    !i_tx_retry |=> o_ctl.tx_fifo_threshold_sel ==
      $past(tuning[ltr_pkg::THR_LSB +: 2]))
    else $error("threshold not the programmed one");

  AST_EFF_2K: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    !i_tx_retry && tuning[ltr_pkg::THR_LSB +: 2] != ltr_pkg::THR_2K
      |=> !o_tx_threshold_eff_2k)
    else $error("store and forward without cause");

  AST_MASTER_STAMP: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    !phy_en |=> !o_ctl.music_stamp_fix && !o_ctl.video_stamp_fix &&
      !o_music_fix_now && !o_video_fix_now)
    else $error("stamp fix without master enable");

  AST_PRIO_ON: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    phy_en && tuning[ltr_pkg::PRIO_BIT] |=> o_ctl.priority_request)
    else $error("priority request not enabled");

  AST_IDLE_ON: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    phy_en && tuning[ltr_pkg::IDLE_BIT] |=> o_ctl.idle_insertion)
    else $error("idle insertion not enabled");

  AST_SPEED_ON: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    phy_en && tuning[ltr_pkg::SPEED_BIT] |=> o_ctl.speedup_features)
    else $error("speedup features not enabled");

  AST_MUSIC_ON: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    phy_en && tuning[ltr_pkg::MUSIC_BIT] && i_tx_fmt == ltr_pkg::FMT_MUSIC
      |=> o_music_fix_now && o_ctl.music_stamp_fix)
    else $error("music fix missing");

  AST_VIDEO_ON: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    phy_en && tuning[ltr_pkg::VIDEO_BIT] && i_tx_fmt == ltr_pkg::FMT_VIDEO
      |=> o_video_fix_now && o_ctl.video_stamp_fix)
    else $error("video fix missing");

endmodule : ltr_regs

// File: tb/test_ltr_regs.sv
// self-checking bench for the link tuning and identity registers
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module test_ltr_regs;
  // ==========================================================================
  // signals and model state
  logic               i_mclk, i_nrst, i_wr, i_rd, i_tx_retry;
  logic               i_phy_tuning_master_en;
  logic [7:0]         i_addr, i_tx_fmt;
  logic [31:0]        i_wdata, o_rdata, tun, sid, d;
  ltr_pkg::ltr_load_s i_load;
  ltr_pkg::ltr_ctl_s  o_ctl;
  logic               o_music_fix_now, o_video_fix_now, o_tx_threshold_eff_2k;
  int                 n_errors, total_checks;

  ltr_regs u_dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_load(i_load),
    .i_phy_tuning_master_en(i_phy_tuning_master_en),
    .i_tx_retry(i_tx_retry), .i_tx_fmt(i_tx_fmt), .o_rdata(o_rdata),
    .o_ctl(o_ctl), .o_music_fix_now(o_music_fix_now),
    .o_video_fix_now(o_video_fix_now),
    .o_tx_threshold_eff_2k(o_tx_threshold_eff_2k));

  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  // ==========================================================================
  // bus tasks; the model updates only once the strobe has been taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_mclk);
    i_addr  <= a;
    i_wdata <= v;
    i_wr    <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    if (a == 8'hF4) tun = v & ltr_pkg::TUNING_RW_MASK;
    else if (a == 8'hF8 || a == 8'h2C) sid = v;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic [31:0] e;
    e = (a == 8'hF4) ? tun : (a == 8'hF8 || a == 8'h2C) ? sid : 32'h0;
    @(posedge i_mclk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    `CHK(o_rdata, e)
  endtask : rd

  // levels settle well inside 5 cycles, master enable has 3 flops
  task automatic chk_ctl;
    logic       g;
    logic [1:0] t;
    repeat (5) @(posedge i_mclk);
    #1;
    g = i_phy_tuning_master_en;
    t = i_tx_retry ? 2'h0 : tun[13:12];
    `CHK(o_ctl, {t, g & tun[9], g & tun[8], g & tun[7], g & tun[2], g & tun[1]})
    `CHK(o_tx_threshold_eff_2k, t == 2'h0)
    `CHK(o_music_fix_now, g & tun[9] & (i_tx_fmt == 8'h10))
    `CHK(o_video_fix_now, g & tun[8] & (i_tx_fmt == 8'h00))
  endtask : chk_ctl

  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  // ==========================================================================
  // tests
  initial begin
    void'($urandom(51));
    {i_nrst, i_wr, i_rd, i_tx_retry, i_phy_tuning_master_en} = 5'h00;
    {i_addr, i_tx_fmt, i_wdata} = 48'h0;
    i_load = '0;
    tun = ltr_pkg::TUNING_RESET;
    sid = ltr_pkg::ID_RESET;
    repeat (4) @(posedge i_mclk);
    i_nrst <= 1'b1;
    rd(8'hF4);
    rd(8'hF8);
    rd(8'h2C);
    rd(8'hF0);
    chk_ctl;
    $display("reset values done");
    i_phy_tuning_master_en <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      d[13:12] = i[1:0];
      wr(8'hF4, d);
      wr(8'hF0, 32'hFFFF_FFFF);
      rd(8'hF4);
      i_tx_retry <= i[2];
      i_tx_fmt <= (i % 3 == 0) ? 8'h10 : (i % 3 == 1) ? 8'h00 : 8'($urandom);
      chk_ctl;
    end
    i_tx_retry <= 1'b0;
    $display("tuning fields done");
    wr(8'h2C, $urandom);
    rd(8'hF8);
    wr(8'hF8, $urandom);
    rd(8'h2C);
    // back to back: write the alias, read the standard slot next cycle
    d = $urandom;
    @(posedge i_mclk);
    i_addr  <= 8'hF8;
    i_wdata <= d;
    i_wr    <= 1'b1;
    sid = d;
    @(posedge i_mclk);
    i_wr   <= 1'b0;
    i_rd   <= 1'b1;
    i_addr <= 8'h2C;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    `CHK(o_rdata, sid)
    $display("identity alias done");
    d = $urandom;
    @(posedge i_mclk);
    i_load <= '{valid: 1'b1, addr: 8'hF4, data: d};
    @(posedge i_mclk);
    i_load <= '{valid: 1'b1, addr: 8'hF8, data: ~d};
    tun = d & ltr_pkg::TUNING_RW_MASK;
    @(posedge i_mclk);
    i_load  <= '{valid: 1'b1, addr: 8'hF8, data: d};
    i_addr  <= 8'hF4;
    i_wdata <= ~d;
    i_wr    <= 1'b1;
    sid = ~d;
    @(posedge i_mclk);
    i_load.valid <= 1'b0;
    i_wr <= 1'b0;
    tun = ~d & ltr_pkg::TUNING_RW_MASK;
    rd(8'hF4);
    rd(8'hF8);
    chk_ctl;
    $display("rom load done");
    i_phy_tuning_master_en <= 1'b0;
    wr(8'hF4, 32'hFFFF_FFFF);
    i_tx_fmt <= 8'h10;
    chk_ctl;
    $display("master enable done");
    close_out();
  end

  // full run is about 140 cycles; allow ample margin
  initial begin
    #(3000 * 100);
    n_errors++;
    close_out();
  end
endmodule : test_ltr_regs
